// ===== rtl/gpc_pkg.sv
// Shared constants and carriers for the three-port GPIO block.
// Assumes an 8-bit register address space and 8-bit register data.
package gpc_pkg;

    // Register data and address widths, and the fifth-port width
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned E_W    = 3;

    // Register offsets
    localparam logic [7:0] OFS_THIRD_PINS  = 8'h07;
    localparam logic [7:0] OFS_FOURTH_PINS = 8'h08;
    localparam logic [7:0] OFS_FIFTH_PINS  = 8'h09;
    localparam logic [7:0] OFS_THIRD_DIR   = 8'h87;
    localparam logic [7:0] OFS_FOURTH_DIR  = 8'h88;
    localparam logic [7:0] OFS_FIFTH_CTRL  = 8'h89;
    localparam logic [7:0] OFS_ANALOG_CFG  = 8'h9F;

    // Reset values
    localparam logic [7:0] RST_THIRD_DIR   = 8'hFF;
    localparam logic [7:0] RST_FOURTH_DIR  = 8'hFF;
    localparam logic [2:0] RST_FIFTH_DIR   = 3'h7;
    localparam logic [2:0] RST_ANALOG_MASK = 3'h7;
    localparam logic [7:0] RST_LATCH       = 8'h00;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;

    // Fields of the fifth-port direction and slave control register
    localparam int unsigned CTRL_IN_FULL_BIT  = 7;
    localparam int unsigned CTRL_OUT_FULL_BIT = 6;
    localparam int unsigned CTRL_IN_OVF_BIT   = 5;
    localparam int unsigned CTRL_PSS_BIT      = 4;
    localparam int unsigned E_DIR_MSB         = 2;

    // Fifth-port pin roles in parallel slave mode
    localparam int unsigned E_RD_BIT = 0;
    localparam int unsigned E_WR_BIT = 1;
    localparam int unsigned E_CS_BIT = 2;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } gpc_req_t;

    // Peripheral override for one 8-pin port
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] out;
        logic [7:0] oe;
    } gpc_periph_t;

    // Parallel slave handshake status and drive, from the slave port logic
    typedef struct packed {
        logic       in_buffer_full;
        logic       out_buffer_full;
        logic       in_buffer_overflow;
        logic       drive;
        logic [7:0] data;
    } gpc_psp_t;

    // Parallel slave control inputs, active low, seen at the pins
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_n;
    } gpc_psp_ctrl_t;

endpackage : gpc_pkg

// ===== rtl/gpc_port.sv
// Output latch and direction register of one port.
// Assumes write enables are one-cycle pulses decoded by the parent.
module gpc_port #(
    parameter int unsigned   W       = 8,
    parameter logic [W-1:0]  DIR_RST = '1
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // Register writes
    input  wire logic [W-1:0] wdata_i,
    input  wire logic         latch_we_i,
    input  wire logic         dir_we_i,
    // Stored values
    output logic      [W-1:0] latch_o,
    output logic      [W-1:0] dir_o
);

    logic [W-1:0] latch_q;
    logic [W-1:0] dir_q;

    if (W < 1 || W > gpc_pkg::DATA_W) begin : g_bad_width
        $error("gpc_port: W must lie between 1 and the data width");
    end

    // Output latch; reset loads zero before the first write
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            latch_q <= gpc_pkg::RST_LATCH[W-1:0];
        end else if (latch_we_i) begin
            latch_q <= wdata_i;
        end
    end

    // Direction register; a one makes the pin an input
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dir_q <= DIR_RST;
        end else if (dir_we_i) begin
            dir_q <= wdata_i;
        end
    end

    assign latch_o = latch_q;
    assign dir_o   = dir_q;

endmodule : gpc_port

// ===== rtl/gpc_ports.sv
// Top of the three-port GPIO block: register slave, pin muxing, slave-mode routing.
// Assumes a one-cycle strobe register master on clock_i and pins outside the clock domain.

module gpc_ports (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    // Register bus
    input  wire gpc_pkg::gpc_req_t     req_i,
    output logic                [7:0]  rdata_o,
    // Third port pins and peripheral overrides
    input  wire logic           [7:0]  third_pin_i,
    output logic                [7:0]  third_pin_o,
    output logic                [7:0]  third_pin_oe_o,
    input  wire gpc_pkg::gpc_periph_t  third_periph_i,
    output logic                [7:0]  third_level_o,
    // Fourth port pins and parallel slave data
    input  wire logic           [7:0]  fourth_pin_i,
    output logic                [7:0]  fourth_pin_o,
    output logic                [7:0]  fourth_pin_oe_o,
    input  wire gpc_pkg::gpc_psp_t     psp_i,
    output logic                [7:0]  parallel_slave_data_o,
    // Fifth port pins and slave control
    input  wire logic           [2:0]  fifth_pin_i,
    output logic                [2:0]  fifth_pin_o,
    output logic                [2:0]  fifth_pin_oe_o,
    output gpc_pkg::gpc_psp_ctrl_t     psp_ctrl_o,
    output logic                       parallel_slave_select_o,
    output logic                       ovf_clear_o,
    output logic                [2:0]  analog_sel_o
);

    // Address decode helper used for every write enable
    function automatic logic hit(input gpc_pkg::gpc_req_t r, input logic [7:0] ofs);
        hit = (r.addr == ofs);
    endfunction : hit

    // Per-pin output select: peripheral or port value
    function automatic logic [7:0] pick(input logic [7:0] sel, input logic [7:0] alt,
                                        input logic [7:0] own);
        pick = (sel & alt) | (~sel & own);
    endfunction : pick

    // Write enables
    logic        we_third_pins;
    logic        we_fourth_pins;
    logic        we_fifth_pins;
    logic        we_third_dir;
    logic        we_fourth_dir;
    logic        we_fifth_ctrl;
    logic        we_analog;

    // Stored register values
    logic [7:0]  third_latch;
    logic [7:0]  third_dir;
    logic [7:0]  fourth_latch;
    logic [7:0]  fourth_dir;
    logic [2:0]  fifth_latch;
    logic [2:0]  fifth_dir;
    logic        pss_q;
    logic [2:0]  analog_q;
    logic        ovf_clear_q;

    // Filtered pin levels
    logic [7:0]  third_lvl;
    logic [7:0]  fourth_lvl;
    logic [2:0]  fifth_lvl;

    // Read path
    logic [7:0]  rdata_d;
    logic [7:0]  rdata_q;
    logic [7:0]  ctrl_view;

    // Pin drive, computed then registered
    logic [7:0]  third_out_d;
    logic [7:0]  third_oe_d;
    logic [7:0]  fourth_out_d;
    logic [7:0]  fourth_oe_d;
    logic [2:0]  fifth_out_d;
    logic [2:0]  fifth_oe_d;
    logic [7:0]  third_out_q;
    logic [7:0]  third_oe_q;
    logic [7:0]  fourth_out_q;
    logic [7:0]  fourth_oe_q;
    logic [2:0]  fifth_out_q;
    logic [2:0]  fifth_oe_q;
    gpc_pkg::gpc_psp_ctrl_t ctrl_d;
    gpc_pkg::gpc_psp_ctrl_t ctrl_q;

    // Write decode; reads and writes never share a cycle
    assign we_third_pins  = req_i.we && hit(req_i, gpc_pkg::OFS_THIRD_PINS);
    assign we_fourth_pins = req_i.we && hit(req_i, gpc_pkg::OFS_FOURTH_PINS);
    assign we_fifth_pins  = req_i.we && hit(req_i, gpc_pkg::OFS_FIFTH_PINS);
    assign we_third_dir   = req_i.we && hit(req_i, gpc_pkg::OFS_THIRD_DIR);
    assign we_fourth_dir  = req_i.we && hit(req_i, gpc_pkg::OFS_FOURTH_DIR);
    assign we_fifth_ctrl  = req_i.we && hit(req_i, gpc_pkg::OFS_FIFTH_CTRL);
    assign we_analog      = req_i.we && hit(req_i, gpc_pkg::OFS_ANALOG_CFG);

    // Third port latch and direction
    gpc_port #(
        .W       (8),
        .DIR_RST (gpc_pkg::RST_THIRD_DIR)
    ) u_third (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .wdata_i    (req_i.wdata),
        .latch_we_i (we_third_pins),
        .dir_we_i   (we_third_dir),
        .latch_o    (third_latch),
        .dir_o      (third_dir)
    );

    // Fourth port latch and direction
    gpc_port #(
        .W       (8),
        .DIR_RST (gpc_pkg::RST_FOURTH_DIR)
    ) u_fourth (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .wdata_i    (req_i.wdata),
        .latch_we_i (we_fourth_pins),
        .dir_we_i   (we_fourth_dir),
        .latch_o    (fourth_latch),
        .dir_o      (fourth_dir)
    );

    // Fifth port latch and direction, low bits of the control register
    gpc_port #(
        .W       (gpc_pkg::E_W),
        .DIR_RST (gpc_pkg::RST_FIFTH_DIR)
    ) u_fifth (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .wdata_i    (req_i.wdata[gpc_pkg::E_DIR_MSB:0]),
        .latch_we_i (we_fifth_pins),
        .dir_we_i   (we_fifth_ctrl),
        .latch_o    (fifth_latch),
        .dir_o      (fifth_dir)
    );

    // Pin synchronisers for all three ports
    gpc_sync #(.W(8)) u_sync_third (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (third_pin_i),
        .level_o (third_lvl)
    );

    gpc_sync #(.W(8)) u_sync_fourth (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (fourth_pin_i),
        .level_o (fourth_lvl)
    );

    gpc_sync #(.W(gpc_pkg::E_W)) u_sync_fifth (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (fifth_pin_i),
        .level_o (fifth_lvl)
    );

    // Slave select bit; status bits above it belong to the slave port logic
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pss_q <= 1'b0;
        end else if (we_fifth_ctrl) begin
            pss_q <= req_i.wdata[gpc_pkg::CTRL_PSS_BIT];
        end
    end

    // Overflow flag is cleared in software by writing a zero to it
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ovf_clear_q <= 1'b0;
        end else begin
            ovf_clear_q <= we_fifth_ctrl && !req_i.wdata[gpc_pkg::CTRL_IN_OVF_BIT];
        end
    end

    // Analog selection; every fifth-port pin starts analog
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            analog_q <= gpc_pkg::RST_ANALOG_MASK;
        end else if (we_analog) begin
            analog_q <= req_i.wdata[gpc_pkg::E_DIR_MSB:0];
        end
    end

    // Control register as software sees it; bit 3 unimplemented
    always_comb begin
        ctrl_view = gpc_pkg::ZERO_BYTE;
        ctrl_view[gpc_pkg::CTRL_IN_FULL_BIT]  = psp_i.in_buffer_full;
        ctrl_view[gpc_pkg::CTRL_OUT_FULL_BIT] = psp_i.out_buffer_full;
        ctrl_view[gpc_pkg::CTRL_IN_OVF_BIT]   = psp_i.in_buffer_overflow;
        ctrl_view[gpc_pkg::CTRL_PSS_BIT]      = pss_q;
        ctrl_view[gpc_pkg::E_DIR_MSB:0]       = fifth_dir;
    end

    // Read mux; unmapped addresses and idle cycles return zero
    always_comb begin
        rdata_d = gpc_pkg::ZERO_BYTE;
        if (req_i.re) begin
            unique case (req_i.addr)
                gpc_pkg::OFS_THIRD_PINS:  rdata_d = third_lvl;
                gpc_pkg::OFS_FOURTH_PINS: rdata_d = fourth_lvl;
                gpc_pkg::OFS_FIFTH_PINS:  rdata_d = {5'h00, fifth_lvl & ~analog_q};
                gpc_pkg::OFS_THIRD_DIR:   rdata_d = third_dir;
                gpc_pkg::OFS_FOURTH_DIR:  rdata_d = fourth_dir;
                gpc_pkg::OFS_FIFTH_CTRL:  rdata_d = ctrl_view;
                gpc_pkg::OFS_ANALOG_CFG:  rdata_d = {5'h00, analog_q};
                default:                  rdata_d = gpc_pkg::ZERO_BYTE;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_q <= gpc_pkg::ZERO_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Third port: enabled peripherals take over value and enable per pin
    always_comb begin
        third_out_d = pick(third_periph_i.sel, third_periph_i.out, third_latch);
        third_oe_d  = pick(third_periph_i.sel, third_periph_i.oe, ~third_dir);
    end

    // Fourth port: in slave mode the slave logic owns the drivers
    always_comb begin
        if (pss_q) begin
            fourth_out_d = psp_i.data;
            fourth_oe_d  = {8{psp_i.drive}};
        end else begin
            fourth_out_d = fourth_latch;
            fourth_oe_d  = ~fourth_dir;
        end
    end

    // Fifth port: direction applies whether or not a pin is analog
    always_comb begin
        fifth_out_d = fifth_latch;
        fifth_oe_d  = ~fifth_dir;
    end

    // Slave controls idle high outside slave mode so no stray strobe is seen
    always_comb begin
        ctrl_d.rd_n = 1'b1;
        ctrl_d.wr_n = 1'b1;
        ctrl_d.cs_n = 1'b1;
        if (pss_q) begin
            ctrl_d.rd_n = fifth_lvl[gpc_pkg::E_RD_BIT];
            ctrl_d.wr_n = fifth_lvl[gpc_pkg::E_WR_BIT];
            ctrl_d.cs_n = fifth_lvl[gpc_pkg::E_CS_BIT];
        end
    end

    // Pin drive registers; all pins released during reset
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            third_out_q  <= gpc_pkg::ZERO_BYTE;
            third_oe_q   <= gpc_pkg::ZERO_BYTE;
            fourth_out_q <= gpc_pkg::ZERO_BYTE;
            fourth_oe_q  <= gpc_pkg::ZERO_BYTE;
            fifth_out_q  <= 3'h0;
            fifth_oe_q   <= 3'h0;
        end else begin
            third_out_q  <= third_out_d;
            third_oe_q   <= third_oe_d;
            fourth_out_q <= fourth_out_d;
            fourth_oe_q  <= fourth_oe_d;
            fifth_out_q  <= fifth_out_d;
            fifth_oe_q   <= fifth_oe_d;
        end
    end

    // Slave control register; the slave logic counts on software having set
    // the fifth pins to digital inputs before the select bit
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_q <= '1;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Outputs
    assign rdata_o                 = rdata_q;
    assign third_pin_o             = third_out_q;
    assign third_pin_oe_o          = third_oe_q;
    assign third_level_o           = third_lvl;
    assign fourth_pin_o            = fourth_out_q;
    assign fourth_pin_oe_o         = fourth_oe_q;
    assign parallel_slave_data_o   = fourth_lvl;
    assign fifth_pin_o             = fifth_out_q;
    assign fifth_pin_oe_o          = fifth_oe_q;
    assign psp_ctrl_o              = ctrl_q;
    assign parallel_slave_select_o = pss_q;
    assign ovf_clear_o             = ovf_clear_q;
    assign analog_sel_o            = analog_q;

endmodule : gpc_ports

// ===== rtl/gpc_sync.sv
// Three-flop pin synchroniser with agreement filter.
// Assumes the inputs are asynchronous to clock_i.
module gpc_sync #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // Pin levels in, filtered levels out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;

    if (W < 1) begin : g_bad_width
        $error("gpc_sync: W must be at least 1");
    end

    // Stage chain; first stage feeds only the second
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a bit only once two late stages agree, dropping one-cycle glitches
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            level_q <= '0;
        end else begin
            for (int i = 0; i < int'(W); i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign level_o = level_q;

endmodule : gpc_sync

// ===== verification/gpc_pin_model.sv
// Far-side model: external sources meeting the block's pin drivers.
// Assumes the bench offers an external level for every pin at all times.
module gpc_pin_model #(
    parameter int unsigned W = 19
) (
    // Block drive
    input  wire logic [W-1:0] pin_o_i,
    input  wire logic [W-1:0] pin_oe_i,
    // External drive
    input  wire logic [W-1:0] ext_i,
    // Resolved level
    output logic      [W-1:0] level_o
);
    // External source yields wherever the block drives, so no contention
    assign level_o = (pin_o_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule : gpc_pin_model

// ===== verification/gpc_ports_monitor.sv
// Port-level checker for the three-port GPIO block.
// Assumes one clock domain, synchronous active-low reset, bound to gpc_ports.
module gpc_ports_monitor (
    // Clock and reset
    input wire logic                   clock_i,
    input wire logic                   rst_n_i,
    // Register bus
    input wire gpc_pkg::gpc_req_t      req_i,
    input wire logic            [7:0]  rdata_o,
    // Pin drive
    input wire logic            [7:0]  third_pin_o,
    input wire logic            [7:0]  third_pin_oe_o,
    input wire gpc_pkg::gpc_periph_t   third_periph_i,
    input wire logic            [7:0]  fourth_pin_o,
    input wire logic            [7:0]  fourth_pin_oe_o,
    input wire gpc_pkg::gpc_psp_t      psp_i,
    input wire logic            [2:0]  fifth_pin_oe_o,
    // Mode and control
    input wire gpc_pkg::gpc_psp_ctrl_t psp_ctrl_o,
    input wire logic                   parallel_slave_select_o,
    input wire logic            [2:0]  analog_sel_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Direction register writes, decoded once
    wire logic wr_third  = req_i.we && req_i.addr == gpc_pkg::OFS_THIRD_DIR;
    wire logic wr_fourth = req_i.we && req_i.addr == gpc_pkg::OFS_FOURTH_DIR;
    wire logic wr_fifth  = req_i.we && req_i.addr == gpc_pkg::OFS_FIFTH_CTRL;

    // Drivers off and pins analog right after reset
    a_reset_state: assert property (!$past(rst_n_i) |->
        third_pin_oe_o == 8'h00 && fourth_pin_oe_o == 8'h00 && fifth_pin_oe_o == 3'h0
        && analog_sel_o == 3'h7 && !parallel_slave_select_o)
        else $error("pin drivers or modes wrong after reset");
    // A direction write reaches the driver two edges later
    a_third_dir: assert property (wr_third ##1 (!wr_third && third_periph_i.sel == 8'h00)
        |=> third_pin_oe_o == ~$past(req_i.wdata, 2))
        else $error("third port enables do not follow direction");
    a_fourth_dir: assert property (wr_fourth ##1 (!wr_fourth && !parallel_slave_select_o)
        |=> fourth_pin_oe_o == ~$past(req_i.wdata, 2))
        else $error("fourth port enables do not follow direction");
    a_fifth_dir: assert property (wr_fifth ##1 !wr_fifth
        |=> fifth_pin_oe_o == ~$past(req_i.wdata[2:0], 2))
        else $error("fifth port enables do not follow direction");
    // Peripheral override takes the selected pins
    a_periph_out: assert property (third_periph_i.sel != 8'h00 |=>
        ((third_pin_o ^ $past(third_periph_i.out)) & $past(third_periph_i.sel)) == 8'h00)
        else $error("peripheral value not on selected pins");
    a_periph_oe: assert property (third_periph_i.sel != 8'h00 |=>
        ((third_pin_oe_o ^ $past(third_periph_i.oe)) & $past(third_periph_i.sel)) == 8'h00)
        else $error("peripheral enable not on selected pins");
    // Slave mode hands the fourth port to the slave data path
    a_slave_drive: assert property (parallel_slave_select_o |=>
        fourth_pin_o == $past(psp_i.data) && fourth_pin_oe_o == {8{$past(psp_i.drive)}})
        else $error("fourth port not driven by slave data");
    // Controls stay inactive outside slave mode
    a_ctrl_idle: assert property (!parallel_slave_select_o &&
        !$past(parallel_slave_select_o) |-> psp_ctrl_o == 3'h7)
        else $error("slave controls active outside slave mode");
    a_analog_read: assert property (req_i.re && req_i.addr == gpc_pkg::OFS_FIFTH_PINS
        |=> (rdata_o & {5'h1F, $past(analog_sel_o)}) == 8'h00)
        else $error("analog pin or unused bit read as one");
    // Read data only in the cycle after a read strobe
    a_read_idle: assert property (!$past(req_i.re) |-> rdata_o == 8'h00)
        else $error("read data outside read answer cycle");

    // Main scenarios reached
    c_slave: cover property (parallel_slave_select_o && psp_i.drive);
    c_periph: cover property (third_periph_i.sel != 8'h00);
    c_analog: cover property (req_i.re && req_i.addr == gpc_pkg::OFS_FIFTH_PINS);
endmodule : gpc_ports_monitor

bind gpc_ports gpc_ports_monitor gpc_ports_monitor_inst (
    .clock_i, .rst_n_i, .req_i, .rdata_o, .third_pin_o, .third_pin_oe_o, .third_periph_i,
    .fourth_pin_o, .fourth_pin_oe_o, .psp_i, .fifth_pin_oe_o, .psp_ctrl_o,
    .parallel_slave_select_o, .analog_sel_o);

// ===== verification/gpc_ports_tb_top.sv
// Self-checking bench for the three-port GPIO block.
// Assumes the pin model closes the pin loops and the checker is bound.
module gpc_ports_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   clock_i;
    logic                   rst_n_i;
    gpc_pkg::gpc_req_t      req;
    gpc_pkg::gpc_periph_t   periph;
    gpc_pkg::gpc_psp_t      parallel_slave_data;
    gpc_pkg::gpc_psp_ctrl_t ctrl;
    logic            [7:0]  rdata;
    logic            [7:0]  third_lvl;
    logic            [7:0]  psd;
    logic            [18:0] ext;
    wire logic       [18:0] pin_o;
    wire logic       [18:0] pin_oe;
    wire logic       [18:0] pin_lvl;
    logic                   sel;
    logic                   ovf;
    logic            [2:0]  ana;
    int                     errors;
    int                     n_tests;
    // Rows of address, write data, expected read back
    logic            [23:0] rows [7] = '{24'h875A5A, 24'h88C3C3, 24'h890A02,
                                         24'h890707, 24'h9FFF07, 24'h9F0707, 24'h55AA00};

    gpc_ports gpc_ports_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
        .third_pin_i(pin_lvl[7:0]), .third_pin_o(pin_o[7:0]), .third_pin_oe_o(pin_oe[7:0]),
        .third_periph_i(periph), .third_level_o(third_lvl),
        .fourth_pin_i(pin_lvl[15:8]), .fourth_pin_o(pin_o[15:8]),
        .fourth_pin_oe_o(pin_oe[15:8]), .psp_i(parallel_slave_data), .parallel_slave_data_o(psd),
        .fifth_pin_i(pin_lvl[18:16]), .fifth_pin_o(pin_o[18:16]),
        .fifth_pin_oe_o(pin_oe[18:16]), .psp_ctrl_o(ctrl), .parallel_slave_select_o(sel),
        .ovf_clear_o(ovf), .analog_sel_o(ana));

    gpc_pin_model #(.W(19)) gpc_pin_model_inst (
        .pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext), .level_o(pin_lvl));

    // Clock at 100 ns period
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check8

    // One-cycle write strobe, released on the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clock_i);
        req.we <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clock_i);
        req.re <= 1'b0;
        #1 check8("read data", exp, rdata);
    endtask : rdc

    // Long enough for the pin filter and output registers
    task automatic settle();
        repeat (8) @(posedge clock_i);
        #1;
    endtask : settle

    task automatic reset_vals();
        rdc(8'h87, 8'hFF);
        rdc(8'h88, 8'hFF);
        rdc(8'h89, 8'h07);
        rdc(8'h9F, 8'h07);
        check8("third enables", 8'h00, pin_oe[7:0]);
    endtask : reset_vals

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Watchdog, far beyond the fewer than two hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clock_i);
        errors++;
        close_out();
    end

    // Main sequence
    initial begin
        errors = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        req = '0;
        periph = '0;
        parallel_slave_data = '0;
        ext = {3'h5, 8'h96, 8'h3C};
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        reset_vals();
        foreach (rows[k]) begin
            wr(rows[k][23:16], rows[k][15:8]);
            rdc(rows[k][23:16], rows[k][7:0]);
        end
        // Third port as plain output, then two pins taken by peripherals
        wr(8'h87, 8'h00);
        wr(8'h07, 8'hA5);
        settle();
        check8("third out", 8'hA5, pin_o[7:0]);
        check8("third enables", 8'hFF, pin_oe[7:0]);
        rdc(8'h07, 8'hA5);
        periph <= '{sel: 8'h81, out: 8'h01, oe: 8'h80};
        settle();
        check8("third mixed out", 8'h25, pin_o[7:0]);
        check8("third mixed enables", 8'hFE, pin_oe[7:0]);
        check8("third level", 8'h24, third_lvl);
        periph <= '0;
        wr(8'h87, 8'hFF);
        settle();
        rdc(8'h07, 8'h3C);
        // Fifth port: analog pins read zero, drivers still follow direction
        rdc(8'h09, 8'h00);
        wr(8'h9F, 8'h01);
        #1 check8("analog select", 8'h01, {5'h00, ana});
        rdc(8'h09, 8'h04);
        wr(8'h9F, 8'h07);
        wr(8'h89, 8'h00);
        #1 check8("overflow clear", 8'h01, {7'h00, ovf});
        wr(8'h09, 8'h06);
        settle();
        check8("fifth enables", 8'h07, {5'h00, pin_oe[18:16]});
        check8("fifth out", 8'h06, {5'h00, pin_o[18:16]});
        check8("overflow idle", 8'h00, {7'h00, ovf});
        wr(8'h89, 8'h07);
        // Fourth port with mixed directions
        wr(8'h88, 8'h0F);
        wr(8'h08, 8'h5A);
        settle();
        check8("fourth out", 8'h5A, pin_o[15:8]);
        check8("fourth enables", 8'hF0, pin_oe[15:8]);
        wr(8'h88, 8'hFF);
        // Slave mode: pins digital inputs first, bit 3 written but ignored
        wr(8'h9F, 8'h00);
        wr(8'h89, 8'h1F);
        parallel_slave_data <= '{in_buffer_full: 1'b1, out_buffer_full: 1'b0, in_buffer_overflow: 1'b1,
                 drive: 1'b1, data: 8'h3C};
        ext[18:16] <= 3'h6;
        settle();
        check8("slave out", 8'h3C, pin_o[15:8]);
        check8("slave enables", 8'hFF, pin_oe[15:8]);
        check8("slave controls", 8'h03, {5'h00, ctrl});
        check8("slave select", 8'h01, {7'h00, sel});
        rdc(8'h89, 8'hB7);
        parallel_slave_data.drive <= 1'b0;
        settle();
        check8("slave data in", 8'h96, psd);
        wr(8'h89, 8'h07);
        settle();
        check8("idle controls", 8'h07, {5'h00, ctrl});
        // Reset in mid-run restores the power-on state; disturb directions first
        wr(8'h88, 8'h00);
        wr(8'h87, 8'h00);
        parallel_slave_data <= '0;
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        reset_vals();
        close_out();
    end
endmodule : gpc_ports_tb_top
